/* logic/hsw_pkg.sv */
package hsw_pkg;

    // ------------------------------------------------------------------
    // Clock and time base
    // ------------------------------------------------------------------
    localparam int CLK_HZ       = 25_000_000;
    localparam int TICK_US      = 100;
    localparam int TICK_CYC     = CLK_HZ / 1_000_000 * TICK_US;
    localparam int PWM_SLOW_HZ  = 200;
    localparam int PWM_FAST_HZ  = 400;
    localparam int PWM_STEPS    = 255;
    localparam int PWM_SLOW_CYC = CLK_HZ / (PWM_SLOW_HZ * PWM_STEPS);
    localparam int PWM_FAST_CYC = CLK_HZ / (PWM_FAST_HZ * PWM_STEPS);

    // On-times in microseconds, periods in milliseconds
    localparam int ON_T1_US  = 100;
    localparam int ON_T2_US  = 300;
    localparam int ON_T3_US  = 1000;
    localparam int ON_T4_US  = 10000;
    localparam int ON_T5_US  = 20000;
    localparam int PER_T0_MS = 10;
    localparam int PER_T1_MS = 20;
    localparam int PER_T2_MS = 50;
    localparam int PER_T3_MS = 100;
    localparam int PER_T4_MS = 200;
    localparam int PER_T5_MS = 1000;
    localparam int PER_T6_MS = 2000;

    // ------------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_TMR_A = 7'h0C;
    localparam logic [6:0] ADDR_TMR_B = 7'h0D;
    localparam logic [6:0] ADDR_SD    = 7'h10;
    localparam logic [6:0] ADDR_SEL_A = 7'h14;
    localparam logic [6:0] ADDR_SEL_B = 7'h15;
    localparam logic [7:0] REG_RST    = 8'h00;
    localparam logic [7:0] CFG_MASK   = 8'h77;
    localparam logic [7:0] SD_MASK    = 8'h70;
    localparam int         ON_LSB     = 4;
    localparam int         PER_LSB    = 0;
    localparam int         SEL_HI_LSB = 4;
    localparam int         SEL_LO_LSB = 0;
    localparam int         OVD_BIT    = 6;
    localparam int         UVD_BIT    = 5;
    localparam int         REC_BIT    = 4;

    // Field codes
    localparam logic [2:0] SEL_OFF   = 3'h0;
    localparam logic [2:0] SEL_ON    = 3'h1;
    localparam logic [2:0] SEL_TMR_A = 3'h2;
    localparam logic [2:0] SEL_TMR_B = 3'h3;
    localparam logic [2:0] SEL_PWM_A = 3'h4;
    localparam logic [2:0] SEL_PWM_B = 3'h5;
    localparam logic [2:0] ON_LOW    = 3'h0;
    localparam logic [2:0] ON_HIGH   = 3'h6;
    localparam logic [2:0] CODE_RSV  = 3'h7;

    typedef enum logic [1:0] {TMR_LOW, TMR_HIGH, TMR_RUN} hsw_tmr_st_t;

    // ------------------------------------------------------------------
    // Code tables in timer ticks
    // ------------------------------------------------------------------
    function automatic logic [14:0] hsw_on_ticks(input logic [2:0] c);
        case (c)
            3'h1:    return 15'(ON_T1_US / TICK_US);
            3'h2:    return 15'(ON_T2_US / TICK_US);
            3'h3:    return 15'(ON_T3_US / TICK_US);
            3'h4:    return 15'(ON_T4_US / TICK_US);
            3'h5:    return 15'(ON_T5_US / TICK_US);
            default: return 15'h0000;
        endcase
    endfunction : hsw_on_ticks

    function automatic logic [14:0] hsw_per_ticks(input logic [2:0] c);
        case (c)
            3'h0:    return 15'(PER_T0_MS * 1000 / TICK_US);
            3'h1:    return 15'(PER_T1_MS * 1000 / TICK_US);
            3'h2:    return 15'(PER_T2_MS * 1000 / TICK_US);
            3'h3:    return 15'(PER_T3_MS * 1000 / TICK_US);
            3'h4:    return 15'(PER_T4_MS * 1000 / TICK_US);
            3'h5:    return 15'(PER_T5_MS * 1000 / TICK_US);
            3'h6:    return 15'(PER_T6_MS * 1000 / TICK_US);
            default: return 15'h0001;
        endcase
    endfunction : hsw_per_ticks

endpackage : hsw_pkg

/* logic/hsw_cyc_timer.sv */
`timescale 1ns/1ps
module hsw_cyc_timer
    import hsw_pkg::*;
#(
    parameter int TICK_CYC_P = TICK_CYC
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    input  wire logic       start_i,
    input  wire logic [2:0] on_code_i,
    input  wire logic [2:0] per_code_i,
    output logic            drive_o
);

    typedef struct packed {
        hsw_tmr_st_t st;
        logic [11:0] div;
        logic [14:0] pos;
        logic        drive;
    } hsw_tmr_state_t;

    hsw_tmr_state_t s_q;
    hsw_tmr_state_t s_d;

    // ------------------------------------------------------------------
    // Period and on-time sequencing
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        if (on_code_i == ON_LOW || on_code_i == CODE_RSV || per_code_i == CODE_RSV) begin
            s_d.st = TMR_LOW; // [R01] [R22]
        end else if (on_code_i == ON_HIGH) begin
            s_d.st = TMR_HIGH; // [R02]
        end else begin
            s_d.st = TMR_RUN; // [R06]
        end
        if (start_i || s_d.st != TMR_RUN) begin
            s_d.div = 12'h000;
            s_d.pos = 15'h0000;
        end else if (s_q.div >= 12'(TICK_CYC_P - 1)) begin
            s_d.div = 12'h000;
            if (s_q.pos >= hsw_per_ticks(per_code_i) - 15'h0001) begin
                s_d.pos = 15'h0000; // [R04]
            end else begin
                s_d.pos = s_q.pos + 15'h0001;
            end
        end else begin
            s_d.div = s_q.div + 12'h001;
        end
        case (s_d.st)
            TMR_LOW:  s_d.drive = 1'b0;
            TMR_HIGH: s_d.drive = 1'b1;
            TMR_RUN:  s_d.drive = s_d.pos < hsw_on_ticks(on_code_i); // [R03] [R21]
            default:  s_d.drive = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign drive_o = s_q.drive;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic run_code;
    assign run_code = on_code_i != ON_LOW && on_code_i != ON_HIGH
                      && on_code_i != CODE_RSV && per_code_i != CODE_RSV;

    start_period_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R06]
        start_i && run_code |=> s_q.pos == 15'h0000 && drive_o)
        else $error("timer did not begin a period with the output on");
    off_code_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R01]
        on_code_i == ON_LOW |=> !drive_o)
        else $error("timer output on with off code");
    rsv_code_a: assert property (@(posedge clk_sys_i) disable iff (!rstn_i) // [R22]
        on_code_i == CODE_RSV || per_code_i == CODE_RSV |=> !drive_o && s_q.st == TMR_LOW)
        else $error("timer ran with a reserved code");

endmodule : hsw_cyc_timer

/* logic/hsw_switch_ctrl.sv */
`timescale 1ns/1ps
// Overview of operation
// [R01] Timer B on-time code 000 stops the timer and holds its switches off.
// [R02] Timer B on-time code 110 stops the timer and holds its switches on.
// [R03] On-time codes 001 to 101 give 0.1, 0.3, 1, 10, 20 ms; 111 reserved.
// [R04] Period codes 000 to 110 give 10 ms up to 2 s; 111 reserved.
// [R05] Host assigns a timer to a switch before programming its on-time.
// [R06] Writing a running on-time code starts the timer without a start command.
// [R07] Clearing timer-driven selects in restart state also clears both timer configs; done only once both select registers are 0x00.
// [R08] Reserved bits of all registers read as zero.
// [R09] Shutdown bit 6 set disables switch-off on supply over-voltage.
// [R10] Shutdown bit 5 set disables switch-off on supply under-voltage.
// [R11] Bit 4 set restores switches after a supply fault; cleared, they stay off.
// [R12] Select code 000 turns a switch off, 001 turns it on.
// [R13] Select code 010 hands a switch to timer A, 011 to timer B.
// [R14] Select 100 hands a switch to modulator A, 101 to B; 110, 111 reserved.
// [R15] Select pair A holds switches 2 and 1, pair B switches 4 and 3.
// [R16] Over-current or over-temperature on a switch clears its select field.
// [R17] All registers read 0x00 after power-on and soft reset.
// [R18] Timer A uses the same codes as timer B from its own register.
// [R19] Modulator drives on for duty/255 of each period; 0 off, 255 on.
// [R20] Modulator runs at 200 Hz with its speed bit 0, 400 Hz with 1.
// [R21] A running timer drives on for the on-time at each period start.
// [R22] Reserved select, on-time or period codes keep the switch off.
module hsw_switch_ctrl
    import hsw_pkg::*;
#(
    parameter int TICK_CYC_P = TICK_CYC
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    input  wire logic       soft_reset_i,
    input  wire logic       restart_state_i,
    input  wire logic [6:0] reg_addr_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    input  wire logic [7:0] pwm_a_duty_i,
    input  wire logic [7:0] pwm_b_duty_i,
    input  wire logic       pwm_a_fast_i,
    input  wire logic       pwm_b_fast_i,
    input  wire logic       supply_ov_i,
    input  wire logic       supply_uv_i,
    input  wire logic [3:0] fault_clear_i,
    output logic      [3:0] high_side_out_o
);

    typedef struct packed {
        logic [7:0]      tmr_a;
        logic [7:0]      tmr_b;
        logic [7:0]      sd;
        logic [7:0]      sel_a;
        logic [7:0]      sel_b;
        logic [7:0]      rdata;
        logic            fault;
        logic [1:0][8:0] pdiv;
        logic [1:0][7:0] ppos;
        logic [3:0]      hs;
    } hsw_top_state_t;

    hsw_top_state_t s_q;
    hsw_top_state_t s_d;
    logic [1:0]     tmr_start;
    logic [1:0]     tmr_drive;
    logic [1:0]     pwm_drive;
    logic           fault_now;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [2:0] sel_field(input logic [7:0] a, input logic [7:0] b,
                                             input int i);
        logic [7:0] r;
        r = (i < 2) ? a : b;
        return (i % 2 == 1) ? r[SEL_HI_LSB +: 3] : r[SEL_LO_LSB +: 3]; // [R15]
    endfunction : sel_field

    function automatic logic uses_timer(input logic [7:0] r);
        logic [2:0] hi;
        logic [2:0] lo;
        hi = r[SEL_HI_LSB +: 3];
        lo = r[SEL_LO_LSB +: 3];
        return hi == SEL_TMR_A || hi == SEL_TMR_B || lo == SEL_TMR_A || lo == SEL_TMR_B;
    endfunction : uses_timer

    // ------------------------------------------------------------------
    // Cyclic timers
    // ------------------------------------------------------------------
    hsw_cyc_timer #(.TICK_CYC_P(TICK_CYC_P)) u_tmr_a (
        .clk_sys_i  (clk_sys_i),
        .rstn_i     (rstn_i),
        .start_i    (tmr_start[0]),
        .on_code_i  (s_q.tmr_a[ON_LSB +: 3]),
        .per_code_i (s_q.tmr_a[PER_LSB +: 3]),
        .drive_o    (tmr_drive[0])
    ); // [R18]

    hsw_cyc_timer #(.TICK_CYC_P(TICK_CYC_P)) u_tmr_b (
        .clk_sys_i  (clk_sys_i),
        .rstn_i     (rstn_i),
        .start_i    (tmr_start[1]),
        .on_code_i  (s_q.tmr_b[ON_LSB +: 3]),
        .per_code_i (s_q.tmr_b[PER_LSB +: 3]),
        .drive_o    (tmr_drive[1])
    );

    // ------------------------------------------------------------------
    // Registers, modulators and switch drive
    // ------------------------------------------------------------------
    always_comb begin
        logic [2:0] code;
        logic       fast;
        code      = SEL_OFF;
        fast      = 1'b0;
        s_d       = s_q;
        tmr_start = 2'b00;
        fault_now = (supply_ov_i && !s_q.sd[OVD_BIT])   // [R09]
                    || (supply_uv_i && !s_q.sd[UVD_BIT]); // [R10]
        s_d.fault = fault_now;
        if (reg_wr_i) begin
            case (reg_addr_i)
                ADDR_TMR_A: begin
                    s_d.tmr_a    = reg_wdata_i & CFG_MASK; // [R08]
                    tmr_start[0] = 1'b1;
                end
                ADDR_TMR_B: begin
                    s_d.tmr_b    = reg_wdata_i & CFG_MASK;
                    tmr_start[1] = 1'b1; // [R06]
                end
                ADDR_SD:    s_d.sd    = reg_wdata_i & SD_MASK; // [R08]
                ADDR_SEL_A: s_d.sel_a = reg_wdata_i & CFG_MASK;
                ADDR_SEL_B: s_d.sel_b = reg_wdata_i & CFG_MASK;
                default: ;
            endcase
        end
        if (restart_state_i && (uses_timer(s_q.sel_a) || uses_timer(s_q.sel_b))
            && s_d.sel_a == REG_RST && s_d.sel_b == REG_RST) begin
            s_d.tmr_a = REG_RST; // [R07]
            s_d.tmr_b = REG_RST;
        end
        // Hardware clears win over a host write in the same cycle
        if (fault_clear_i[0]) s_d.sel_a[SEL_LO_LSB +: 3] = SEL_OFF; // [R16]
        if (fault_clear_i[1]) s_d.sel_a[SEL_HI_LSB +: 3] = SEL_OFF;
        if (fault_clear_i[2]) s_d.sel_b[SEL_LO_LSB +: 3] = SEL_OFF;
        if (fault_clear_i[3]) s_d.sel_b[SEL_HI_LSB +: 3] = SEL_OFF;
        if (fault_now && !s_q.fault && !s_q.sd[REC_BIT]) begin
            s_d.sel_a = REG_RST; // [R11]
            s_d.sel_b = REG_RST;
        end
        if (soft_reset_i) begin
            s_d.tmr_a = REG_RST; // [R17]
            s_d.tmr_b = REG_RST;
            s_d.sd    = REG_RST;
            s_d.sel_a = REG_RST;
            s_d.sel_b = REG_RST;
        end
        if (reg_rd_i) begin
            case (reg_addr_i)
                ADDR_TMR_A: s_d.rdata = s_q.tmr_a;
                ADDR_TMR_B: s_d.rdata = s_q.tmr_b;
                ADDR_SD:    s_d.rdata = s_q.sd;
                ADDR_SEL_A: s_d.rdata = s_q.sel_a;
                ADDR_SEL_B: s_d.rdata = s_q.sel_b;
                default:    s_d.rdata = REG_RST;
            endcase
        end
        for (int k = 0; k < 2; k++) begin
            fast = (k == 0) ? pwm_a_fast_i : pwm_b_fast_i;
            if (s_q.pdiv[k] >= 9'(fast ? PWM_FAST_CYC - 1 : PWM_SLOW_CYC - 1)) begin // [R20]
                s_d.pdiv[k] = 9'h000;
                if (s_q.ppos[k] >= 8'(PWM_STEPS - 1)) begin
                    s_d.ppos[k] = 8'h00;
                end else begin
                    s_d.ppos[k] = s_q.ppos[k] + 8'h01;
                end
            end else begin
                s_d.pdiv[k] = s_q.pdiv[k] + 9'h001;
            end
        end
        pwm_drive[0] = s_q.ppos[0] < pwm_a_duty_i; // [R19]
        pwm_drive[1] = s_q.ppos[1] < pwm_b_duty_i;
        for (int i = 0; i < 4; i++) begin
            code = sel_field(s_q.sel_a, s_q.sel_b, i);
            case (code)
                SEL_OFF:   s_d.hs[i] = 1'b0;          // [R12]
                SEL_ON:    s_d.hs[i] = 1'b1;
                SEL_TMR_A: s_d.hs[i] = tmr_drive[0];  // [R13]
                SEL_TMR_B: s_d.hs[i] = tmr_drive[1];
                SEL_PWM_A: s_d.hs[i] = pwm_drive[0];  // [R14]
                SEL_PWM_B: s_d.hs[i] = pwm_drive[1];
                default:   s_d.hs[i] = 1'b0;          // [R22]
            endcase
            if (fault_now) s_d.hs[i] = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata_o     = s_q.rdata;
    assign high_side_out_o = s_q.hs;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rstn_i);

    logic supply_ok;
    assign supply_ok = !supply_ov_i && !supply_uv_i;

    rsvd_zero_a: assert property ((reg_rdata_o & 8'h88) == 8'h00 // [R08]
        && (!$past(reg_rd_i) || $past(reg_addr_i) != ADDR_SD || reg_rdata_o[3:0] == 4'h0))
        else $error("reserved bit read as one");
    soft_clear_a: assert property (soft_reset_i |=> s_q.tmr_a == 8'h00 // [R17]
        && s_q.tmr_b == 8'h00 && s_q.sd == 8'h00 && s_q.sel_a == 8'h00 && s_q.sel_b == 8'h00)
        else $error("soft reset left a register set");
    hw_clear_a: assert property (fault_clear_i[3] |=> s_q.sel_b[6:4] == SEL_OFF) // [R16]
        else $error("switch 4 select not cleared by fault");
    ov_cut_a: assert property (supply_ov_i && !s_q.sd[OVD_BIT] |=> high_side_out_o == 4'h0)
        else $error("switch on during over-voltage"); // [R09]
    uv_cut_a: assert property (supply_uv_i && !s_q.sd[UVD_BIT] |=> high_side_out_o == 4'h0)
        else $error("switch on during under-voltage"); // [R10]
    no_recover_a: assert property (fault_now && !s_q.fault && !s_q.sd[REC_BIT] // [R11]
        && !soft_reset_i |=> s_q.sel_a == 8'h00 && s_q.sel_b == 8'h00)
        else $error("selects kept with recovery disabled");
    sel_on_a: assert property (s_q.sel_a[6:4] == SEL_ON && supply_ok |=> high_side_out_o[1])
        else $error("switch 2 not on with on code"); // [R12]
    tmr_b_low_a: assert property ((s_q.sel_a[2:0] == SEL_TMR_B // [R01]
        && s_q.tmr_b[6:4] == ON_LOW)[*2] |=> !high_side_out_o[0])
        else $error("timer B off code left switch 1 on");
    tmr_b_high_a: assert property ((s_q.sel_a[2:0] == SEL_TMR_B // [R02]
        && s_q.tmr_b[6:4] == ON_HIGH && supply_ok)[*2] |=> high_side_out_o[0])
        else $error("timer B high code left switch 1 off");
    pwm_zero_a: assert property (s_q.sel_b[2:0] == SEL_PWM_A && pwm_a_duty_i == 8'h00
        |=> !high_side_out_o[2])
        else $error("modulator with zero duty drove switch 3"); // [R19]
    rsv_sel_a: assert property (s_q.sel_b[6:4] == 3'h6 |=> !high_side_out_o[3])
        else $error("reserved select drove switch 4"); // [R22]
    restart_clr_a: assert property (restart_state_i && reg_wr_i && reg_addr_i == ADDR_SEL_A
        && reg_wdata_i == 8'h00 && s_q.sel_b == 8'h00 && uses_timer(s_q.sel_a)
        |=> s_q.tmr_a == 8'h00 && s_q.tmr_b == 8'h00)
        else $error("timer settings kept after restart clear"); // [R07]

    tmr_run_c: cover property (s_q.sel_a[2:0] == SEL_TMR_B && high_side_out_o[0]
        ##1 !high_side_out_o[0]);
    pwm_run_c: cover property (s_q.sel_b[2:0] == SEL_PWM_A && $rose(high_side_out_o[2]));
    recover_c: cover property (s_q.fault && s_q.sd[REC_BIT] ##1 !fault_now
        ##1 high_side_out_o != 4'h0);
    restart_c: cover property (restart_state_i && s_q.tmr_b != 8'h00 ##1 s_q.tmr_b == 8'h00);

endmodule : hsw_switch_ctrl

/* tb/hsw_host_model.sv */
`timescale 1ns/1ps
module hsw_host_model (
    input  wire logic       clk_sys_i,
    input  wire logic [7:0] reg_rdata_i,
    output logic      [6:0] reg_addr_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o,
    output logic      [7:0] reg_wdata_o
);
    initial begin
        reg_addr_o  = 7'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
        reg_wdata_o = 8'h00;
    end

    // ------------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------------
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        #1;
        reg_addr_o  = a;
        reg_wdata_o = d;
        reg_wr_o    = 1'b1;
        @(posedge clk_sys_i);
        #1;
        reg_wr_o    = 1'b0;
        // Released lines must not keep showing the old value
        reg_addr_o  = ~a;
        reg_wdata_o = ~d;
    endtask : wr

    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clk_sys_i);
        #1;
        reg_addr_o = a;
        reg_rd_o   = 1'b1;
        @(posedge clk_sys_i);
        #1;
        reg_rd_o   = 1'b0;
        reg_addr_o = ~a;
        @(posedge clk_sys_i);
        #1;
        d = reg_rdata_i;
    endtask : rd
endmodule : hsw_host_model

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
    import hsw_pkg::*;
    logic       clk_sys_i = 1'b0;
    logic       rstn_i = 1'b0;
    logic       soft_reset_i = 1'b0;
    logic       restart_state_i = 1'b0;
    logic [6:0] reg_addr_i;
    logic       reg_wr_i;
    logic       reg_rd_i;
    logic [7:0] reg_wdata_i;
    logic [7:0] reg_rdata_o;
    logic [7:0] pwm_a_duty_i = 8'h00;
    logic [7:0] pwm_b_duty_i = 8'h00;
    logic       pwm_a_fast_i = 1'b0;
    logic       pwm_b_fast_i = 1'b1;
    logic       supply_ov_i = 1'b0;
    logic       supply_uv_i = 1'b0;
    logic [3:0] fault_clear_i = 4'h0;
    logic [3:0] high_side_out_o;
    int         miscompares = 0;
    int         n_compared = 0;

    always #20 clk_sys_i = ~clk_sys_i;

    hsw_switch_ctrl #(.TICK_CYC_P(4)) uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .soft_reset_i(soft_reset_i), .restart_state_i(restart_state_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .pwm_a_duty_i(pwm_a_duty_i), .pwm_b_duty_i(pwm_b_duty_i),
        .pwm_a_fast_i(pwm_a_fast_i), .pwm_b_fast_i(pwm_b_fast_i),
        .supply_ov_i(supply_ov_i), .supply_uv_i(supply_uv_i),
        .fault_clear_i(fault_clear_i), .high_side_out_o(high_side_out_o));

    hsw_host_model host (.clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata_o),
        .reg_addr_o(reg_addr_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
        .reg_wdata_o(reg_wdata_i));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : cyc

    task automatic rchk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, e);
    endtask : rchk

    task automatic ochk(input logic [3:0] e);
        cyc(3);
        chk({4'h0, high_side_out_o}, {4'h0, e});
    endtask : ochk

    task automatic hcnt(input int b, input int n, input logic [7:0] e);
        int c;
        c = 0;
        repeat (n) begin
            @(posedge clk_sys_i);
            #1;
            c += int'(high_side_out_o[b]);
        end
        chk(8'(c), e);
    endtask : hcnt

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        logic [6:0] a[4] = '{ADDR_TMR_B, ADDR_SD, ADDR_SEL_A, ADDR_SEL_B};
        logic [7:0] m[4] = '{8'h77, 8'h70, 8'h77, 8'h77};
        foreach (a[i]) rchk(a[i], 8'h00);
        foreach (a[i]) host.wr(a[i], 8'hFF);
        host.wr(7'h20, 8'hFF);
        foreach (a[i]) rchk(a[i], m[i]);
        rchk(7'h20, 8'h00);
        @(posedge clk_sys_i);
        #1;
        soft_reset_i = 1'b1;
        cyc(1);
        soft_reset_i = 1'b0;
        foreach (a[i]) rchk(a[i], 8'h00);
    endtask : t_regs

    task automatic t_select();
        logic [2:0] code[4] = '{SEL_ON, SEL_OFF, 3'h6, CODE_RSV};
        for (int n = 0; n < 4; n++) begin
            foreach (code[k]) begin
                host.wr(n < 2 ? ADDR_SEL_A : ADDR_SEL_B, 8'(code[k]) << (4 * (n % 2)));
                ochk(code[k] == SEL_ON ? 4'(1 << n) : 4'h0);
            end
        end
        pwm_a_duty_i = 8'hFF;
        host.wr(ADDR_SEL_A, {1'b0, SEL_PWM_B, 1'b0, SEL_PWM_A});
        ochk(4'h1);
        cyc(300);
        chk({4'h0, high_side_out_o}, 8'h01);
        host.wr(ADDR_SEL_A, 8'h00);
    endtask : t_select

    task automatic t_timers();
        host.wr(ADDR_SEL_A, {1'b0, SEL_TMR_A, 1'b0, SEL_TMR_B});
        host.wr(ADDR_TMR_B, {1'b0, ON_HIGH, 4'h0});
        ochk(4'h1);
        host.wr(ADDR_TMR_B, 8'h00);
        ochk(4'h0);
        host.wr(ADDR_TMR_B, 8'h10);
        cyc(2);
        hcnt(0, 400, 8'd4);
        host.wr(ADDR_TMR_B, 8'h32);
        cyc(2);
        hcnt(0, 2000, 8'd40);
        host.wr(ADDR_TMR_B, 8'h70);
        ochk(4'h0);
        host.wr(ADDR_TMR_A, 8'h20);
        cyc(2);
        hcnt(1, 400, 8'd12);
    endtask : t_timers

    task automatic t_supply();
        host.wr(ADDR_SEL_A, 8'h01);
        host.wr(ADDR_SD, 8'h00);
        supply_ov_i = 1'b1;
        ochk(4'h0);
        supply_ov_i = 1'b0;
        ochk(4'h0);
        host.wr(ADDR_SD, 8'h10);
        host.wr(ADDR_SEL_A, 8'h01);
        supply_uv_i = 1'b1;
        ochk(4'h0);
        supply_uv_i = 1'b0;
        ochk(4'h1);
        host.wr(ADDR_SD, 8'h60);
        supply_ov_i = 1'b1;
        supply_uv_i = 1'b1;
        ochk(4'h1);
        supply_ov_i = 1'b0;
        supply_uv_i = 1'b0;
    endtask : t_supply

    task automatic t_fault();
        host.wr(ADDR_SEL_A, 8'h11);
        host.wr(ADDR_SEL_B, 8'h11);
        fault_clear_i = 4'hA;
        cyc(1);
        fault_clear_i = 4'h0;
        ochk(4'h5);
        rchk(ADDR_SEL_A, 8'h01);
        rchk(ADDR_SEL_B, 8'h01);
    endtask : t_fault

    task automatic t_restart();
        host.wr(ADDR_SEL_B, 8'h00);
        host.wr(ADDR_SEL_A, 8'h03);
        host.wr(ADDR_TMR_B, 8'h11);
        restart_state_i = 1'b1;
        host.wr(ADDR_SEL_A, 8'h00);
        cyc(2);
        restart_state_i = 1'b0;
        rchk(ADDR_TMR_B, 8'h00);
        rchk(ADDR_TMR_A, 8'h00);
        ochk(4'h0);
    endtask : t_restart

    task automatic t_pwm();
        int c0 = 0;
        int c1 = 0;
        pwm_a_duty_i = 8'h01;
        pwm_b_duty_i = 8'h01;
        @(posedge clk_sys_i);
        #1;
        rstn_i = 1'b0;
        cyc(2);
        rstn_i = 1'b1;
        rchk(ADDR_SD, 8'h00);
        host.wr(ADDR_SEL_A, {1'b0, SEL_PWM_B, 1'b0, SEL_PWM_A});
        repeat (600) begin
            cyc(1);
            c0 += int'(high_side_out_o[0]);
            c1 += int'(high_side_out_o[1]);
        end
        // Duty one lasts one step; the slow step outlasts the fast one by a known span
        chk(8'(c0 - c1), 8'(PWM_SLOW_CYC - PWM_FAST_CYC));
    endtask : t_pwm

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    task automatic wrap_up();
        $display("compared %0d mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #(40 * 60000);
        miscompares++;
        wrap_up();
    end

    initial begin
        repeat (20) @(posedge clk_sys_i);
        #1;
        rstn_i = 1'b1;
        t_regs();
        t_select();
        t_timers();
        t_supply();
        t_fault();
        t_restart();
        t_pwm();
        wrap_up();
    end
endmodule : tb
